// *** serial_channel_pkg.sv ***
/*
  Constants for the serial channel core: register offsets, field positions,
  reset values, clock source codes and averaged-rate increments.
  Assumes a 200 MHz APB clock and one 32-bit word per register.
*/
`default_nettype none

package serial_channel_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] EXT_OFS = 8'h08;
  localparam logic [7:0] TXDATA_OFS = 8'h0c;
  localparam logic [7:0] RXDATA_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] DIVISOR_OFS = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_SYNC_BIT = 7;
  localparam int MODE_CHR_BIT = 6;
  localparam int MODE_PE_BIT = 5;
  localparam int MODE_ODD_BIT = 4;
  localparam int MODE_STOP_BIT = 3;
  localparam int MODE_MP_BIT = 2;
  localparam int CTRL_TXEN_BIT = 5;
  localparam int CTRL_RXEN_BIT = 4;
  localparam int CTRL_EXTCLK_BIT = 1;
  localparam int CTRL_PINOUT_BIT = 0;
  localparam int EXT_HALF_BIT = 3;
  localparam int TXDATA_FLAG_BIT = 8;
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL = 6;
  localparam int ST_OVERRUN = 5;
  localparam int ST_FRAMING = 4;
  localparam int ST_PARITY = 3;
  localparam int ST_TX_END = 2;
  localparam int ST_BREAK = 1;
  localparam int ST_STATION = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] EXT_RST = 8'h00;
  localparam logic [15:0] DIVISOR_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Clock source codes and oversampling
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_PIN = 3'h0, SRC_AVG_115_A = 3'h1, SRC_AVG_460_A = 3'h2, SRC_RESERVED = 3'h3,
    SRC_TIMER = 3'h4, SRC_AVG_115_B = 3'h5, SRC_AVG_460_B = 3'h6, SRC_AVG_720 = 3'h7
  } clk_src_e;

  localparam logic [3:0] OS16_TOP = 4'hf;
  localparam logic [3:0] OS16_MID = 4'h7;
  localparam logic [3:0] OS8_TOP = 4'h7;
  localparam logic [3:0] OS8_MID = 4'h3;
  localparam logic [3:0] SYNC_BITS_LAST = 4'h7;

  // Averaged-rate generators: phase increment = base clock / pclk * 2^32
  localparam longint CLK_HZ = 200000000;
  localparam longint RATE_115_A_BPS = 115152;
  localparam longint RATE_460_A_BPS = 460606;
  localparam longint RATE_115_B_BPS = 115196;
  localparam longint RATE_460_B_BPS = 460784;
  localparam longint RATE_720_BPS = 720000;
  localparam logic [31:0] INC_115_A = 32'((RATE_115_A_BPS * 16 * 64'h100000000) / CLK_HZ);
  localparam logic [31:0] INC_460_A = 32'((RATE_460_A_BPS * 8 * 64'h100000000) / CLK_HZ);
  localparam logic [31:0] INC_115_B = 32'((RATE_115_B_BPS * 16 * 64'h100000000) / CLK_HZ);
  localparam logic [31:0] INC_460_B = 32'((RATE_460_B_BPS * 16 * 64'h100000000) / CLK_HZ);
  localparam logic [31:0] INC_720 = 32'((RATE_720_BPS * 8 * 64'h100000000) / CLK_HZ);

endpackage

`default_nettype wire

// *** serial_rate_divider.sv ***
/*
  Programmable divider: one-cycle tick every divisor+1 clocks.
  Assumes the divisor is held stable by software while the channel runs.
*/
`default_nettype none

module serial_rate_divider #(
  parameter int WIDTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);

  logic [WIDTH-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= divisor) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + 1'b1;
      tick <= 1'b0;
    end
  end

endmodule // serial_rate_divider

`default_nettype wire

// *** serial_channel_core.sv ***
/*
  Serial channel core: APB registers, clock source selection, asynchronous
  framing transmitter and receiver, clocked synchronous shift engine.
  Assumes rxd, sclk_in and timer outputs are synchronous to pclk.
*/
`default_nettype none

// Operation
// - Mode bit 7 picks asynchronous (0) or clocked synchronous (1)
// - Asynchronous: length bit 0 gives 8 data bits, 1 gives 7
// - Optional parity or station flag; stop field 0 gives one stop, 1 gives two
// - Asynchronous receive flags framing, parity, overrun and break
// - Internal asynchronous clock: pin unused, or bit-rate clock out when enabled
// - Synchronous mode: fixed 8 bits, no parity or stop, overrun only
// - Synchronous internal clock: baud generator drives clock out on pin
// - Synchronous external clock: shift with the clock from the pin
// - Source 000 takes pin clock at 16x or 8x per halving bit
// - Source 100 clocks from AND of two timer outputs, pin unused
// - Other codes select averaged-rate generators, 011 reserved, pin unused
// - Transmitter and receiver run independently at the same time
// - Both directions double-buffered for back-to-back frames
// - Line idles high; falling edge starts reception
// - Frame: low start, data LSB first, optional parity, high stops
// - Sync on start falling edge; 16x sampling latches on 8th pulse
// - Halving bit gives 8x sampling, latching on 4th pulse
// - Twelve formats; parity enable ignored in station flag format
// - Station flag bit follows data, in parity position, then stops
// - Extended source code only acts in asynchronous external mode
// - Averaged-rate generators fix oversampling regardless of halving bit
module serial_channel_core
  import serial_channel_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxd,
  output logic txd,
  input wire logic sclk_in,
  output logic sclk_out,
  output logic sclk_oe,
  input wire logic timer_ch1_output_a,
  input wire logic timer_ch2_output_a
);
  import serial_channel_pkg::*;

  typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} tx_state_e;
  typedef enum logic [1:0] {RX_IDLE, RX_BITS} rx_state_e;

  logic [7:0] serial_mode_reg, serial_control_reg, channel0_extended_mode_reg;
  logic [15:0] divisor;
  logic [7:0] tx_buf, rx_buf;
  logic tx_buf_flag, tx_full, tx_end, rx_full;
  logic overrun_err, framing_err, parity_err, break_seen, station_flag_bit;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  logic sync_mode, char_length_select, parity_enable, multiproc_format, two_stops;
  logic clock_source_external, clock_pin_output, tx_en, rx_en, base_clock_halving;
  logic ext_src_active, avg_sel, os_eight;
  logic [2:0] async_clock_source_sel;
  logic [3:0] os_top, os_mid, n_data, stop_idx;
  logic has_extra;

  assign sync_mode = serial_mode_reg[MODE_SYNC_BIT];
  assign char_length_select = serial_mode_reg[MODE_CHR_BIT];
  assign parity_enable = serial_mode_reg[MODE_PE_BIT];
  assign multiproc_format = serial_mode_reg[MODE_MP_BIT];
  assign two_stops = serial_mode_reg[MODE_STOP_BIT];
  assign clock_source_external = serial_control_reg[CTRL_EXTCLK_BIT];
  assign clock_pin_output = serial_control_reg[CTRL_PINOUT_BIT];
  assign tx_en = serial_control_reg[CTRL_TXEN_BIT];
  assign rx_en = serial_control_reg[CTRL_RXEN_BIT];
  assign base_clock_halving = channel0_extended_mode_reg[EXT_HALF_BIT];
  assign async_clock_source_sel = channel0_extended_mode_reg[2:0];
  assign ext_src_active = !sync_mode && clock_source_external;
  assign avg_sel = ext_src_active && async_clock_source_sel != SRC_PIN
    && async_clock_source_sel != SRC_TIMER && async_clock_source_sel != SRC_RESERVED;
  assign os_eight = avg_sel ? (async_clock_source_sel == SRC_AVG_460_A
    || async_clock_source_sel == SRC_AVG_720) : base_clock_halving;
  assign os_top = os_eight ? OS8_TOP : OS16_TOP;
  assign os_mid = os_eight ? OS8_MID : OS16_MID;
  assign n_data = char_length_select ? 4'h7 : 4'h8;
  assign has_extra = multiproc_format || parity_enable;
  assign stop_idx = n_data + {3'h0, has_extra} + 4'h1;

  // ----------------------------------------------------------------
  // Clock sources
  // ----------------------------------------------------------------
  logic baud_tick, sclk_in_d, timer_and_d, acc_carry, base_tick;
  logic pin_rise, pin_fall, timer_rise;
  logic [31:0] phase_acc, phase_inc;

  serial_rate_divider #(.WIDTH(16)) baud_gen (
    .pclk(pclk),
    .presetn(presetn),
    .divisor(divisor),
    .tick(baud_tick)
  );

  assign pin_rise = sclk_in && !sclk_in_d;
  assign pin_fall = !sclk_in && sclk_in_d;
  assign timer_rise = timer_ch1_output_a && timer_ch2_output_a && !timer_and_d;

  always_comb begin
    unique case (async_clock_source_sel)
      SRC_AVG_115_A: phase_inc = INC_115_A;
      SRC_AVG_460_A: phase_inc = INC_460_A;
      SRC_AVG_115_B: phase_inc = INC_115_B;
      SRC_AVG_460_B: phase_inc = INC_460_B;
      SRC_AVG_720: phase_inc = INC_720;
      default: phase_inc = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_in_d <= 1'b1;
      timer_and_d <= 1'b0;
      phase_acc <= 32'h0000_0000;
      acc_carry <= 1'b0;
    end else begin
      sclk_in_d <= sclk_in;
      timer_and_d <= timer_ch1_output_a && timer_ch2_output_a;
      {acc_carry, phase_acc} <= {1'b0, phase_acc} + {1'b0, phase_inc};
    end
  end

  always_comb begin
    if (!ext_src_active) begin
      base_tick = baud_tick;
    end else begin
      unique case (async_clock_source_sel)
        SRC_PIN: base_tick = pin_rise;
        SRC_TIMER: base_tick = timer_rise;
        SRC_RESERVED: base_tick = 1'b0;
        default: base_tick = acc_carry;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access, wr_mode, wr_ctrl, wr_ext, wr_tx, wr_status, wr_div, rd_rx, mapped;
  logic [31:0] rd_mux;
  logic [7:0] status_word;

  assign access = psel && penable && pready && paddr[31:8] == 24'h000000;
  assign wr_mode = access && pwrite && paddr[7:0] == MODE_OFS;
  assign wr_ctrl = access && pwrite && paddr[7:0] == CTRL_OFS;
  assign wr_ext = access && pwrite && paddr[7:0] == EXT_OFS;
  assign wr_tx = access && pwrite && paddr[7:0] == TXDATA_OFS;
  assign wr_status = access && pwrite && paddr[7:0] == STATUS_OFS;
  assign wr_div = access && pwrite && paddr[7:0] == DIVISOR_OFS;
  assign rd_rx = access && !pwrite && paddr[7:0] == RXDATA_OFS;
  assign status_word = {!tx_full, rx_full, overrun_err, framing_err, parity_err, tx_end, break_seen,
    station_flag_bit};

  always_comb begin
    mapped = paddr[31:8] == 24'h000000;
    unique case (paddr[7:0])
      MODE_OFS: rd_mux = {24'h000000, serial_mode_reg};
      CTRL_OFS: rd_mux = {24'h000000, serial_control_reg};
      EXT_OFS: rd_mux = {24'h000000, channel0_extended_mode_reg};
      TXDATA_OFS: rd_mux = {23'h000000, tx_buf_flag, tx_buf};
      RXDATA_OFS: rd_mux = {24'h000000, rx_buf};
      STATUS_OFS: rd_mux = {24'h000000, status_word};
      DIVISOR_OFS: rd_mux = {16'h0000, divisor};
      default: begin
        rd_mux = 32'h0000_0000;
        mapped = 1'b0;
      end
    endcase
  end

  // Answer one cycle into the access phase; unmapped reads give zero and an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        pslverr <= !mapped;
        prdata <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_mode_reg <= MODE_RST;
      serial_control_reg <= CTRL_RST;
      channel0_extended_mode_reg <= EXT_RST;
      divisor <= DIVISOR_RST;
    end else begin
      if (wr_mode) serial_mode_reg <= pwdata[7:0];
      if (wr_ctrl) serial_control_reg <= pwdata[7:0];
      if (wr_ext) channel0_extended_mode_reg <= {4'h0, pwdata[3:0]};
      if (wr_div) divisor <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Transmit frame assembly
  // ----------------------------------------------------------------
  logic [10:0] frame_bits;
  logic [3:0] frame_len;
  logic tx_extra;

  always_comb begin
    tx_extra = multiproc_format ? tx_buf_flag :
      ((char_length_select ? ^tx_buf[6:0] : ^tx_buf) ^ serial_mode_reg[MODE_ODD_BIT]);
    for (int i = 0; i < 11; i++) begin
      if (4'(i) < n_data) frame_bits[i] = tx_buf[i % 8];
      else if (4'(i) == n_data && has_extra) frame_bits[i] = tx_extra;
      else frame_bits[i] = 1'b1;
    end
    frame_len = stop_idx + {3'h0, two_stops};
  end

  // ----------------------------------------------------------------
  // Transmitter
  // ----------------------------------------------------------------
  tx_state_e tx_state;
  logic [10:0] tx_shift;
  logic [3:0] tx_left, tx_os, sync_cnt;
  logic tx_load, sync_run, sync_start, sync_fall, sync_rise, sync_done, async_done;
  logic [7:0] sync_rx_shift;

  // Free-running bit phase so the clock out is continuous and frames align to it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_os <= 4'h0;
    else if (base_tick) tx_os <= (tx_os >= os_top) ? 4'h0 : tx_os + 4'h1;
  end

  assign tx_load = !sync_mode && tx_en && tx_full && base_tick && tx_os >= os_top
    && (tx_state == TX_IDLE || tx_left == 4'h0);
  assign async_done = !sync_mode && tx_state == TX_SHIFT && base_tick && tx_os >= os_top
    && tx_left == 4'h0 && !tx_load;
  assign sync_start = sync_mode && !sync_run && ((tx_en && tx_full) || (rx_en && !tx_en && !rx_full));
  // Internal clock: a tick with the pin high makes the fall, with it low the rise
  assign sync_fall = clock_source_external ? pin_fall : (baud_tick && sclk_out && sync_run);
  assign sync_rise = clock_source_external ? pin_rise : (baud_tick && !sclk_out && sync_run);
  assign sync_done = sync_run && sync_rise && sync_cnt == SYNC_BITS_LAST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_shift <= 11'h7ff;
      tx_left <= 4'h0;
      txd <= 1'b1;
    end else if (sync_mode) begin
      tx_state <= TX_IDLE;
      if (!tx_en) begin
        txd <= 1'b1;
      end else if (sync_start) begin
        tx_shift <= {3'h7, tx_buf};
        txd <= tx_buf[0];
      end else if (sync_run && sync_fall && sync_cnt != 4'h0) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        txd <= tx_shift[1];
      end
    end else if (!tx_en) begin
      // Disabling the transmitter abandons a frame in flight
      tx_state <= TX_IDLE;
      txd <= 1'b1;
    end else if (tx_load) begin
      tx_state <= TX_SHIFT;
      tx_shift <= frame_bits;
      tx_left <= frame_len;
      txd <= 1'b0;
    end else if (tx_state == TX_SHIFT && base_tick && tx_os >= os_top) begin
      if (tx_left == 4'h0) begin
        tx_state <= TX_IDLE;
        txd <= 1'b1;
      end else begin
        txd <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

  // Transmit buffer; a write in the same cycle as a load still lands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_buf <= 8'h00;
      tx_buf_flag <= 1'b0;
      tx_full <= 1'b0;
      tx_end <= 1'b1;
    end else begin
      if (wr_tx) begin
        tx_buf <= pwdata[7:0];
        tx_buf_flag <= pwdata[TXDATA_FLAG_BIT];
      end
      tx_full <= wr_tx || (tx_full && !tx_load && !(sync_start && tx_en));
      tx_end <= !wr_tx && (tx_end || async_done || (sync_done && tx_en));
    end
  end

  // ----------------------------------------------------------------
  // Synchronous shift engine and serial clock pin
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_run <= 1'b0;
      sync_cnt <= 4'h0;
      sync_rx_shift <= 8'h00;
    end else if (!sync_mode) begin
      sync_run <= 1'b0;
      sync_cnt <= 4'h0;
    end else if (sync_start) begin
      sync_run <= 1'b1;
      sync_cnt <= 4'h0;
    end else if (sync_run && sync_rise) begin
      sync_rx_shift <= {rxd, sync_rx_shift[7:1]};
      sync_cnt <= sync_cnt + 4'h1;
      if (sync_done) sync_run <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_out <= 1'b1;
      sclk_oe <= 1'b0;
    end else if (sync_mode) begin
      sclk_oe <= !clock_source_external;
      if (baud_tick && (sync_run || !sclk_out)) sclk_out <= !sclk_out;
    end else begin
      sclk_oe <= !clock_source_external && clock_pin_output;
      sclk_out <= tx_os > os_mid;
    end
  end

  // ----------------------------------------------------------------
  // Asynchronous receiver
  // ----------------------------------------------------------------
  rx_state_e rx_state;
  logic [10:0] rx_shift;
  logic [3:0] rx_os, rx_idx;
  logic rx_prev, rx_sample, rx_done, rx_all_low;
  logic [7:0] rx_data_bits;
  logic rx_extra;

  assign rx_sample = rx_state == RX_BITS && base_tick && rx_os == os_mid;
  assign rx_done = rx_sample && rx_idx == stop_idx;
  assign rx_data_bits = char_length_select ? {1'b0, rx_shift[7:1]} : rx_shift[8:1];
  assign rx_extra = rx_shift[n_data + 4'h1];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
      rx_os <= 4'h0;
      rx_idx <= 4'h0;
      rx_shift <= 11'h000;
      rx_all_low <= 1'b1;
    end else if (sync_mode || !rx_en) begin
      rx_state <= RX_IDLE;
      rx_prev <= 1'b1;
    end else if (base_tick) begin
      rx_prev <= rxd;
      unique case (rx_state)
        RX_IDLE: begin
          if (rx_prev && !rxd) begin
            rx_state <= RX_BITS;
            rx_os <= 4'h1;
            rx_idx <= 4'h0;
            rx_all_low <= 1'b1;
          end
        end
        RX_BITS: begin
          rx_os <= (rx_os >= os_top) ? 4'h0 : rx_os + 4'h1;
          if (rx_os == os_mid) begin
            rx_shift[rx_idx] <= rxd;
            rx_all_low <= rx_all_low && !rxd;
            rx_idx <= rx_idx + 4'h1;
            // Glitch shorter than half a bit is not a start
            if ((rx_idx == 4'h0 && rxd) || rx_idx == stop_idx) rx_state <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // Receive buffer and flags: hardware set wins over a software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf <= 8'h00;
      rx_full <= 1'b0;
      overrun_err <= 1'b0;
      framing_err <= 1'b0;
      parity_err <= 1'b0;
      break_seen <= 1'b0;
      station_flag_bit <= 1'b0;
    end else begin
      if (rx_done && !rx_full) begin
        rx_buf <= rx_data_bits;
        station_flag_bit <= multiproc_format && rx_extra;
      end else if (sync_done && rx_en && !rx_full) begin
        rx_buf <= {rxd, sync_rx_shift[7:1]};
      end
      rx_full <= ((rx_done || (sync_done && rx_en)) && !rx_full) || (rx_full && !rd_rx);
      overrun_err <= (rx_full && (rx_done || (sync_done && rx_en)))
        || (overrun_err && !(wr_status && pwdata[ST_OVERRUN]));
      framing_err <= (rx_done && !rx_full && !rxd)
        || (framing_err && !(wr_status && pwdata[ST_FRAMING]));
      parity_err <= (rx_done && !rx_full && parity_enable && !multiproc_format
        && (^rx_data_bits ^ rx_extra ^ serial_mode_reg[MODE_ODD_BIT]))
        || (parity_err && !(wr_status && pwdata[ST_PARITY]));
      break_seen <= (rx_done && rx_all_low && !rxd)
        || (break_seen && !(wr_status && pwdata[ST_BREAK]));
    end
  end

endmodule // serial_channel_core

`default_nettype wire

// *** serial_channel_core_checker.sv ***
/* Port checker for serial_channel_core: APB timing and clock pin / line idle behaviour.
   Assumes it is bound to the core and sees only the core's ports. */
`default_nettype none
module serial_channel_core_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txd,
  input wire logic sclk_oe
);
  import serial_channel_pkg::*;
  logic [7:0] mode_q;
  logic [7:0] ctrl_q;
  logic [1:0] quiet;
  wire wr = psel && penable && pready && pwrite && paddr[31:8] == 24'h0;
  // Shadow of mode and control; pins get three cycles to follow any write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_RST;
      ctrl_q <= CTRL_RST;
      quiet <= 2'h0;
    end else begin
      if (wr && paddr[7:0] == MODE_OFS) mode_q <= pwdata[7:0];
      if (wr && paddr[7:0] == CTRL_OFS) ctrl_q <= pwdata[7:0];
      quiet <= wr ? 2'h0 : (quiet == 2'h3 ? quiet : quiet + 2'h1);
    end
  end
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_one_wait: assert property (psel && !penable |=> penable && !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready && paddr[31:8] != 24'h0 |-> pslverr)
    else $error("no slave error on unmapped address");
  a_write_zero: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  a_pin_silent: assert property (quiet == 2'h3 && !mode_q[7] && ctrl_q[1:0] == 2'b00 |-> !sclk_oe)
    else $error("clock pin driven while unused");
  a_pin_clock: assert property (quiet == 2'h3 && !mode_q[7] && ctrl_q[1:0] == 2'b01 |-> sclk_oe)
    else $error("clock pin not driven");
  a_sync_out: assert property (quiet == 2'h3 && mode_q[7] && !ctrl_q[1] |-> sclk_oe)
    else $error("sync internal clock not driven");
  a_ext_in: assert property (quiet == 2'h3 && ctrl_q[1] |-> !sclk_oe)
    else $error("clock pin driven with external clock");
  a_tx_mark: assert property (quiet == 2'h3 && !ctrl_q[5] |-> txd)
    else $error("line not idle high");
endmodule // serial_channel_core_checker
bind serial_channel_core serial_channel_core_checker chk_u (.*);
`default_nettype wire

// *** serial_peer.sv ***
/* Remote asynchronous peer: drives frames onto rxd and captures frames from txd.
   Assumes a bit time of BIT_CYCLES pclk cycles; the line rests high. */
`default_nettype none
module serial_peer #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic pclk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // Frame given bit 0 first (start bit included); called just after an edge
  task automatic send(input logic [11:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      repeat (BIT_CYCLES) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
  // Centre-samples n bits from the next falling edge; gives up after a bound
  task automatic catch_frame(output logic [11:0] bits, input int n);
    int k;
    bits = '1;
    k = 0;
    while (txd !== 1'b0 && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    repeat (BIT_CYCLES / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txd;
      repeat (BIT_CYCLES) @(posedge pclk);
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// *** test_serial_channel_core.sv ***
/* Self-checking bench for serial_channel_core with an asynchronous peer.
   Assumes divisor 0: one base tick per pclk, so 16 pclk per bit. */
`default_nettype none
module test_serial_channel_core;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_channel_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sclk_in = 1, err;
  logic [31:0] paddr = 0, pwdata = 0, prdata, rd;
  logic pready, pslverr, rxd, txd, sclk_out, sclk_oe;
  logic [11:0] got;
  logic [7:0] tx_ctrl = 8'h20;
  logic pin_clk_run = 0;
  int fail_count = 0, checked = 0, cycles = 0;
  always #2.5 pclk = ~pclk;
  // Peer's pin clock toggles every pclk while pin_clk_run is set; t_ext stops it afterwards
  always @(posedge pclk) if (pin_clk_run) sclk_in <= !sclk_in;
  serial_channel_core dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rxd, .txd, .sclk_in, .sclk_out, .sclk_oe, .timer_ch1_output_a(1'b0), .timer_ch2_output_a(1'b0));
  serial_peer peer_u (.pclk, .txd, .rxd);
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("BAD %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic t_regs();
    apb(0, MODE_OFS, 0);
    check(rd, 32'(MODE_RST));
    apb(1, EXT_OFS, 32'hff);
    apb(0, EXT_OFS, 0);
    check(rd, 32'h0f);
    apb(1, EXT_OFS, 0);
    apb(0, 32'h100, 0);
    check({rd[31:1], err}, 32'h1);
  endtask
  // Clock pin direction for each mode and clock choice
  task automatic t_pin();
    logic [15:0] cfg [5] = '{16'h0000, 16'h0001, 16'h8000, 16'h8002, 16'h0002};
    logic [4:0] exp = 5'b00110;
    for (int i = 0; i < 5; i++) begin
      apb(1, MODE_OFS, {24'h0, cfg[i][15:8]});
      apb(1, CTRL_OFS, {24'h0, cfg[i][7:0]});
      repeat (4) @(posedge pclk);
      check({31'h0, sclk_oe}, {31'h0, exp[i]});
    end
    apb(1, EXT_OFS, 32'h4);
    repeat (4) @(posedge pclk);
    check({31'h0, sclk_oe}, 32'h0);
  endtask
  task automatic t_tx(input logic [7:0] mode, input logic [8:0] d, input logic [11:0] want, input int n);
    apb(1, MODE_OFS, {24'h0, mode});
    apb(1, CTRL_OFS, {24'h0, tx_ctrl});
    fork
      peer_u.catch_frame(got, n);
      apb(1, TXDATA_OFS, {23'h0, d});
    join
    check({20'h0, got}, {20'h0, want});
  endtask
  // Error flags are cleared afterwards; the next case's status check proves the clear only for flags it expects low
  task automatic t_rx(input logic [7:0] mode, input logic [11:0] f, input logic [7:0] data, input logic [7:0] st);
    apb(1, MODE_OFS, {24'h0, mode});
    apb(1, CTRL_OFS, 32'h10);
    peer_u.send(f, 10);
    repeat (20) @(posedge pclk);
    apb(0, STATUS_OFS, 0);
    check(rd & 32'h7a, {24'h0, st});
    apb(0, RXDATA_OFS, 0);
    check(rd, {24'h0, data});
    apb(1, STATUS_OFS, 32'h3a);
  endtask
  // Pin clock with 8x sampling: one rise per two pclk keeps 16 pclk per bit
  task automatic t_ext();
    apb(1, EXT_OFS, 32'h08);
    pin_clk_run <= 1'b1;
    tx_ctrl = 8'h22;
    t_tx(8'h00, 9'h05a, {3'b111, 8'h5a, 1'b0}, 10);
    pin_clk_run <= 1'b0;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs();
    t_pin();
    t_tx(8'h00, 9'h0a5, {3'b111, 8'ha5, 1'b0}, 10);
    t_tx(8'h68, 9'h035, {4'b1110, 7'h35, 1'b0}, 11);
    t_tx(8'h24, 9'h0c1, {2'b11, 1'b0, 8'hc1, 1'b0}, 11);
    t_rx(8'h00, {3'b111, 8'h3c, 1'b0}, 8'h3c, 8'h40);
    t_rx(8'h00, {3'b110, 8'h81, 1'b0}, 8'h81, 8'h50);
    t_rx(8'h00, 12'h000, 8'h00, 8'h52);
    t_rx(8'h70, {3'b111, 1'b1, 7'h01, 1'b0}, 8'h01, 8'h48);
    t_ext();
    summarize();
  end
endmodule // test_serial_channel_core
`default_nettype wire
